// ### inc/etc_pkg.sv
// Constants, types and register map of the elapsed-time clock block.
// What this block does
// - Inhibit switch on blocks tick and request.
// - Tick pulses at 50 Hz, 60 Hz or 1 kHz.
// - Idle tick without execute raises request, 3A2, 3Y1.
// - Loop decrements the count word at 0x50.
// - Decrement weight depends on the selected rate.
// - Negative result sets exception, raising interrupt when irq_en enables it.
`default_nettype none
package etc_pkg;

  // ==========================================================================
  // Clock and tick timing.
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned RATE_50_HZ   = 50;
  localparam int unsigned RATE_60_HZ   = 60;
  localparam int unsigned RATE_1K_HZ   = 1000;
  localparam int unsigned TICK_CYC_50  = CLK_HZ / RATE_50_HZ;
  localparam int unsigned TICK_CYC_60  = CLK_HZ / RATE_60_HZ;
  localparam int unsigned TICK_CYC_1K  = CLK_HZ / RATE_1K_HZ;
  localparam int unsigned TICK_CNT_W   = 21;

  // ==========================================================================
  // Rate select encodings and the amount taken off the count per tick.
  localparam logic [1:0]  RATE_SEL_60  = 2'h0;
  localparam logic [1:0]  RATE_SEL_50  = 2'h1;
  localparam logic [1:0]  RATE_SEL_1K  = 2'h2;
  localparam logic [31:0] WEIGHT_60    = 32'h0000_0408;  // 2^3 + 2^10.
  localparam logic [31:0] WEIGHT_50    = 32'h0000_0600;  // 2^9 + 2^10.
  localparam logic [31:0] WEIGHT_1K    = 32'h0000_004D;  // 2^0+2^2+2^3+2^6.

  // ==========================================================================
  // Main-memory word that holds the elapsed-time count.
  localparam logic [31:0] COUNT_ADDR   = 32'h0000_0050;

  // ==========================================================================
  // Register map (byte offsets) and fields.
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h008;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h00C;
  localparam logic [11:0] OFS_STATE    = 12'h010;
  localparam logic [11:0] OFS_LAST     = 12'h014;
  localparam int unsigned STAT_W       = 2;
  localparam int unsigned STAT_DONE    = 0;
  localparam int unsigned STAT_EXC     = 1;
  localparam logic [1:0]  CTRL_RST     = RATE_SEL_60;

  // ==========================================================================
  // Sequencer states: idle is the staticizing level that tests the tick.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_3A2,
    ST_3Y1,
    ST_RD,
    ST_WR
  } etc_fsm_e;

  // Request towards main memory; held until the memory acknowledges.
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } etc_mem_req_s;

  // Whole state of the top module.
  typedef struct packed {
    logic [1:0]        inh_sync;
    logic [1:0]        rate;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] irq_en;
    logic              irq;
    logic              tick_pending;
    logic              req_flag;
    etc_fsm_e          fsm;
    logic [31:0]       last_count;
    etc_mem_req_s      mem;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } etc_state_s;

endpackage : etc_pkg
`default_nettype wire

// ### rtl/etc_tick_gen.sv
// Rate-selected tick divider for the elapsed-time clock.
`timescale 1ns/1ps
`default_nettype none
module etc_tick_gen
  import etc_pkg::*;
#(
  parameter int unsigned CYC_50 = TICK_CYC_50,
  parameter int unsigned CYC_60 = TICK_CYC_60,
  parameter int unsigned CYC_1K = TICK_CYC_1K
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] rate,
  output logic            tick
);

  // ==========================================================================
  // Elaboration checks: each period must fit the counter and exceed one cycle.
  if (CYC_50 < 2 || CYC_60 < 2 || CYC_1K < 2) begin : g_chk_min
    $error("Tick periods must be at least two cycles.");
  end
  if (CYC_50 >= (1 << TICK_CNT_W) || CYC_60 >= (1 << TICK_CNT_W) ||
      CYC_1K >= (1 << TICK_CNT_W)) begin : g_chk_max
    $error("Tick period does not fit the counter.");
  end

  // Period in cycles for a rate code; unknown code falls back to 60 Hz.
  function automatic logic [TICK_CNT_W-1:0] period_of(input logic [1:0] sel);
    logic [TICK_CNT_W-1:0] p;
    p = TICK_CNT_W'(CYC_60);
    if (sel == RATE_SEL_50) begin
      p = TICK_CNT_W'(CYC_50);
    end else if (sel == RATE_SEL_1K) begin
      p = TICK_CNT_W'(CYC_1K);
    end
    return p;
  endfunction : period_of

  logic [TICK_CNT_W-1:0] cnt_reg;
  logic [TICK_CNT_W-1:0] cnt_next;
  logic                  tick_next;

  // Count down; a rate change takes effect at the next wrap, so no short tick.
  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg - TICK_CNT_W'(1);
    if (cnt_reg == '0) begin
      tick_next = 1'b1;
      cnt_next  = period_of(rate) - TICK_CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end

  // ==========================================================================
  // Assertions.
  property p_tick_single;
    @(posedge pclk) disable iff (!presetn)
      tick |=> !tick [*1];
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("Tick pulse longer than one cycle.");

  property p_tick_reload;
    @(posedge pclk) disable iff (!presetn)
      tick |-> (cnt_reg == period_of($past(rate)) - TICK_CNT_W'(1));
  endproperty
  a_tick_reload: assert property (p_tick_reload)
    else $error("Tick counter not reloaded with the selected period.");

endmodule : etc_tick_gen
`default_nettype wire

// ### rtl/etc_elapsed_clock.sv
// Elapsed-time clock: tick capture, count-update loop and APB registers.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module etc_elapsed_clock
  import etc_pkg::*;
#(
  parameter int unsigned CYC_50 = TICK_CYC_50,
  parameter int unsigned CYC_60 = TICK_CYC_60,
  parameter int unsigned CYC_1K = TICK_CYC_1K
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         elapsed_timer_inhibit_switch,
  input  wire logic         execute_phase_flag,
  output etc_mem_req_s      mem,
  input  wire logic [31:0]  mem_rdata,
  input  wire logic         mem_ack,
  output logic              timer_request_flag,
  output logic              elapsed_time_exception_flag,
  output logic              irq
);

  // ==========================================================================
  // Tick source; the rate comes from the state register declared here.
  etc_state_s          r;
  etc_state_s          n;
  logic line_tick_pulse;

  etc_tick_gen #(
    .CYC_50 (CYC_50),
    .CYC_60 (CYC_60),
    .CYC_1K (CYC_1K)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .rate    (r.rate),
    .tick    (line_tick_pulse)
  );

  // ==========================================================================
  // Combinational signals.
  logic [31:0]         weight;
  logic [31:0]         diff;
  logic                set_timer_request;
  logic                acc_wr;
  logic [STAT_W-1:0]   stat_set;
  logic [STAT_W-1:0]   stat_clr;
  logic                inhibit;

  // Weight per tick: per second this takes 61920 at 60 Hz, 76800 at 50 Hz and 77000 at 1 kHz.
  always_comb begin
    weight = WEIGHT_60;
    if (r.rate == RATE_SEL_50) begin
      weight = WEIGHT_50;
    end else if (r.rate == RATE_SEL_1K) begin
      weight = WEIGHT_1K;
    end
  end

  assign diff    = mem_rdata - weight;
  assign inhibit = r.inh_sync[1];

  // Sequencer, flags and register file.
  always_comb begin
    n                 = r;
    stat_set          = '0;
    stat_clr          = '0;
    set_timer_request = 1'b0;
    acc_wr            = psel && penable && r.pready && pwrite;

    // The switch is a panel pin, so it is synchronised before use.
    n.inh_sync = {r.inh_sync[0], elapsed_timer_inhibit_switch};

    // Breaking the tick line while inhibited keeps the sequencer in idle; a loop already past idle still runs to its write.
    if (line_tick_pulse && !inhibit) begin
      n.tick_pending = 1'b1;
    end

    case (r.fsm)
      ST_IDLE: begin
        // A tick is only honoured between instructions.
        set_timer_request = r.tick_pending && !execute_phase_flag && !inhibit;
        if (set_timer_request) begin
          n.req_flag = 1'b1;
          n.fsm      = ST_3A2;
        end
      end
      ST_3A2: begin
        n.fsm = ST_3Y1;
      end
      ST_3Y1: begin
        n.mem.req  = 1'b1;
        n.mem.we   = 1'b0;
        n.mem.addr = COUNT_ADDR;
        n.fsm      = ST_RD;
      end
      ST_RD: begin
        if (mem_ack) begin
          n.mem.we     = 1'b1;
          n.mem.wdata  = diff;
          n.last_count = diff;
          if (diff[31]) begin
            stat_set[STAT_EXC] = 1'b1;
          end
          n.fsm = ST_WR;
        end
      end
      ST_WR: begin
        if (mem_ack) begin
          n.mem.req           = 1'b0;
          n.mem.we            = 1'b0;
          n.req_flag          = 1'b0;
          n.tick_pending      = line_tick_pulse && !inhibit;
          stat_set[STAT_DONE] = 1'b1;
          n.fsm               = ST_IDLE;
        end
      end
      default: begin
        n.fsm = ST_IDLE;
      end
    endcase

    // APB: setup cycle prepares the answer, the access cycle completes it.
    n.pready = 1'b0;
    if (psel && !penable && !r.pready) begin
      n.pready  = 1'b1;
      n.pslverr = 1'b0;
      n.prdata  = '0;
      if (paddr == OFS_CTRL) begin
        n.prdata = {30'h0000_0000, r.rate};
      end else if (paddr == OFS_STATUS) begin
        n.prdata = {30'h0000_0000, r.status};
      end else if (paddr == OFS_IRQ_EN) begin
        n.prdata = {30'h0000_0000, r.irq_en};
      end else if (paddr == OFS_IRQ_CLR) begin
        n.prdata = '0;
      end else if (paddr == OFS_STATE) begin
        n.prdata = {25'h000_0000, inhibit, r.req_flag, r.tick_pending, 4'(r.fsm)};
      end else if (paddr == OFS_LAST) begin
        n.prdata = r.last_count;
      end else begin
        n.pslverr = 1'b1;
      end
    end

    // Writes take effect only at the completing edge.
    if (acc_wr) begin
      if (paddr == OFS_CTRL) begin
        n.rate = pwdata[1:0];
      end else if (paddr == OFS_IRQ_EN) begin
        n.irq_en = pwdata[STAT_W-1:0];
      end else if (paddr == OFS_IRQ_CLR) begin
        stat_clr = pwdata[STAT_W-1:0];
      end
    end

    // A hardware event in the clearing cycle survives the clear.
    n.status = (r.status & ~stat_clr) | stat_set;
    n.irq    = |(n.status & n.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r              <= '0;
      r.rate         <= CTRL_RST;
      r.fsm          <= ST_IDLE;
      // Start inhibited, so no tick is taken before the switch has been sampled.
      r.inh_sync     <= '1;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs, each straight from the state register.
  assign prdata                      = r.prdata;
  assign pready                      = r.pready;
  assign pslverr                     = r.pslverr;
  assign mem                         = r.mem;
  assign timer_request_flag          = r.req_flag;
  assign elapsed_time_exception_flag = r.status[STAT_EXC];
  assign irq                         = r.irq;

  // ==========================================================================
  // Assertions.
  property p_inhibit_blocks;
    @(posedge pclk) disable iff (!presetn)
      $rose(r.tick_pending) |-> $past(line_tick_pulse) && !$past(inhibit);
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks)
    else $error("Tick captured while inhibit was on.");

  property p_inhibit_no_request;
    @(posedge pclk) disable iff (!presetn)
      $rose(timer_request_flag) |-> !$past(inhibit);
  endproperty
  a_inhibit_no_request: assert property (p_inhibit_no_request)
    else $error("Request raised while inhibit was on.");

  property p_request_cause;
    @(posedge pclk) disable iff (!presetn)
      $rose(timer_request_flag) |->
        $past(r.fsm == ST_IDLE) && $past(r.tick_pending) && !$past(execute_phase_flag);
  endproperty
  a_request_cause: assert property (p_request_cause)
    else $error("Request raised without idle tick outside execute.");

  property p_level_order;
    @(posedge pclk) disable iff (!presetn)
      $rose(timer_request_flag) |-> r.fsm == ST_3A2 ##1 r.fsm == ST_3Y1
        ##1 (mem.req && !mem.we && mem.addr == COUNT_ADDR);
  endproperty
  a_level_order: assert property (p_level_order)
    else $error("Levels did not run 3A2 then 3Y1 then read.");

  property p_count_addr;
    @(posedge pclk) disable iff (!presetn)
      mem.req |-> mem.addr == COUNT_ADDR;
  endproperty
  a_count_addr: assert property (p_count_addr)
    else $error("Memory access away from the count word.");

  property p_subtract;
    @(posedge pclk) disable iff (!presetn)
      (r.fsm == ST_RD && mem_ack) |=>
        mem.we && mem.wdata == $past(mem_rdata) - $past(weight);
  endproperty
  a_subtract: assert property (p_subtract)
    else $error("Written count is not read value minus weight.");

  property p_weight_rate;
    @(posedge pclk) disable iff (!presetn)
      (r.fsm == ST_RD && mem_ack && r.rate == RATE_SEL_1K) |=>
        $past(mem_rdata) - mem.wdata == WEIGHT_1K;
  endproperty
  a_weight_rate: assert property (p_weight_rate)
    else $error("Wrong decrement for the 1 kHz rate.");

  property p_negative_exc;
    @(posedge pclk) disable iff (!presetn)
      (r.fsm == ST_RD && mem_ack && diff[31]) |=> elapsed_time_exception_flag;
  endproperty
  a_negative_exc: assert property (p_negative_exc)
    else $error("Negative result did not raise the exception.");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
      (elapsed_time_exception_flag && r.irq_en[STAT_EXC]) |-> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("Enabled exception without interrupt.");

  property p_done_clears;
    @(posedge pclk) disable iff (!presetn)
      (r.fsm == ST_WR && mem_ack && !line_tick_pulse) |=>
        !timer_request_flag && !r.tick_pending && !mem.req && r.fsm == ST_IDLE;
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("Loop end did not clear tick and request.");

  property p_inhibit_idle;
    @(posedge pclk) disable iff (!presetn)
      (inhibit && r.fsm == ST_IDLE) |=> r.fsm == ST_IDLE;
  endproperty
  a_inhibit_idle: assert property (p_inhibit_idle)
    else $error("Loop left idle while inhibit was on.");

  property p_write_back;
    @(posedge pclk) disable iff (!presetn)
      (r.fsm == ST_WR) |-> mem.req && mem.we && mem.wdata == r.last_count;
  endproperty
  a_write_back: assert property (p_write_back)
    else $error("Write-back does not carry the updated count.");

  property p_exc_sticky;
    @(posedge pclk) disable iff (!presetn)
      $fell(elapsed_time_exception_flag) |->
        $past(acc_wr) && $past(paddr) == OFS_IRQ_CLR && $past(pwdata[STAT_EXC]);
  endproperty
  a_exc_sticky: assert property (p_exc_sticky)
    else $error("Exception cleared without a software clear.");

  c_loop: cover property (@(posedge pclk) disable iff (!presetn)
    r.fsm == ST_WR && mem_ack);
  c_exc: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(elapsed_time_exception_flag));
  c_execute_phase_flag_block: cover property (@(posedge pclk) disable iff (!presetn)
    r.fsm == ST_IDLE && r.tick_pending && execute_phase_flag);
  c_slverr: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);

endmodule : etc_elapsed_clock
`default_nettype wire

// ### verification/etc_mem_model.sv
// Main-memory model that holds the elapsed-time count word.
`timescale 1ns/1ps
`default_nettype none
module etc_mem_model
  import etc_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire etc_mem_req_s mem,
  input  wire logic         slow,
  input  wire logic         load,
  input  wire logic [31:0]  load_val,
  output logic [31:0]       mem_rdata,
  output logic              mem_ack,
  output logic [31:0]       wr_count
);
  // ==========================================================================
  // Storage and answer timing.
  logic [31:0] word_reg;
  logic [3:0]  wait_reg;

  // Answers one or six cycles after a request is seen. Outside an answer the
  // data lines toggle, so a stale word can never pass for a fresh one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'hA5A5_A5A5;
      wait_reg  <= 4'h0;
      wr_count  <= 32'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (load) begin
        word_reg <= load_val;
      end
      if (mem.req && !mem_ack) begin
        if (wait_reg == (slow ? 4'h6 : 4'h1)) begin
          mem_ack  <= 1'b1;
          wait_reg <= 4'h0;
          if (mem.we) begin
            word_reg <= mem.wdata;
            wr_count <= wr_count + 32'h1;
          end else begin
            mem_rdata <= word_reg;
          end
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule : etc_mem_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench of the elapsed-time clock.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import etc_pkg::*;
;
  // ==========================================================================
  // Stimulus, result queue and counters.
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [31:0]  pwdata = 32'h0;
  logic         inh = 1'b1;
  logic         exe = 1'b0;
  logic         mslow = 1'b0;
  logic         load = 1'b0;
  logic [31:0]  load_val = 32'h0;
  logic [31:0]  prdata, mem_rdata, wr_count;
  logic         pready, pslverr, mem_ack, trf, etf, irq;
  etc_mem_req_s mem;
  logic [32:0]  exp_q[$];
  logic [31:0]  wt[4];
  int           fail_count = 0;
  int           num_checks = 0;
  int           seed = 32'h99e7;

  // Short tick periods keep each loop within a few dozen cycles.
  etc_elapsed_clock #(.CYC_50(40), .CYC_60(33), .CYC_1K(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .elapsed_timer_inhibit_switch(inh), .execute_phase_flag(exe),
    .mem(mem), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .timer_request_flag(trf),
    .elapsed_time_exception_flag(etf), .irq(irq));

  etc_mem_model u_mem (
    .pclk(pclk), .presetn(presetn), .mem(mem), .slow(mslow), .load(load),
    .load_val(load_val), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .wr_count(wr_count));

  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;

  // ==========================================================================
  // Comparison and bus tasks.
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic pop_chk(input logic [32:0] got);
    if (exp_q.size() == 0) begin
      chk(33'h0, 33'h1);
    end else begin
      chk(got, exp_q.pop_front());
    end
  endtask : pop_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // The request is held from setup until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) chk(33'h0, 33'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_wr(input logic [31:0] t);
    int n;
    n = 0;
    while (wr_count < t && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 3000) chk(33'h0, 33'h1);
  endtask : wait_wr

  // Loads the count, lets k loops run, then inhibits; a note left unused is dropped.
  task automatic run(input logic [1:0] r, input logic [31:0] v, input int k, input logic s);
    apb(1'b1, OFS_CTRL, {30'h0, r});
    mslow <= s;
    load_val <= v;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    inh <= 1'b0;
    for (int i = 1; i <= k + 1; i++) begin
      exp_q.push_back({1'b0, v - wt[r] * i});
      if (i <= k) wait_wr(wr_count + 32'h1);
    end
    inh <= 1'b1;
    cyc(60);
    exp_q.delete();
  endtask : run

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Monitor: each read answer and each count write takes the oldest note.
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite) pop_chk({pslverr, prdata});
    if (mem.req && mem_ack) begin
      chk({1'b0, mem.addr}, {1'b0, COUNT_ADDR});
      if (mem.we) begin
        chk({32'h0, trf}, 33'h1);
        pop_chk({1'b0, mem.wdata});
      end
    end
  end

  // A hang ends the run through the same closing task.
  initial begin
    cyc(40000);
    chk(33'h0, 33'h1);
    final_report();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    logic [31:0] tmp;
    wt = '{WEIGHT_60, WEIGHT_50, WEIGHT_1K, WEIGHT_60};
    cyc(6);
    presetn <= 1'b1;
    rd(OFS_CTRL, {31'h0, CTRL_RST});
    rd(OFS_STATUS, 33'h0);
    rd(12'h03C, {1'b1, 32'h0});
    chk({31'h0, irq, etf}, 33'h0);
    $display("test reset_values done");
    apb(1'b1, OFS_IRQ_EN, 32'h3);
    for (int r = 0; r < 4; r++) begin
      tmp = $random(seed);
      run(2'(r), {2'b01, tmp[29:0]}, 2, r[0]);
      rd(OFS_CTRL, {31'h0, 2'(r)});
      rd(OFS_STATUS, 33'h1);
      rd(OFS_LAST, {1'b0, u_mem.word_reg});
      chk({32'h0, irq}, 33'h1);
      apb(1'b1, OFS_IRQ_CLR, 32'h3);
      cyc(2);
      chk({32'h0, irq}, 33'h0);
    end
    $display("test rates done");
    apb(1'b1, OFS_IRQ_EN, 32'h2);
    run(2'h2, 32'h0000_0010, 1, 1'b0);
    chk({32'h0, etf}, 33'h1);
    chk({32'h0, irq}, 33'h1);
    rd(OFS_STATUS, 33'h3);
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    cyc(2);
    chk({32'h0, irq}, 33'h0);
    apb(1'b1, OFS_IRQ_CLR, 32'h3);
    cyc(2);
    chk({32'h0, etf}, 33'h0);
    $display("test exception done");
    tmp = wr_count;
    cyc(200);
    chk({1'b0, wr_count}, {1'b0, tmp});
    chk({32'h0, trf}, 33'h0);
    exe <= 1'b1;
    inh <= 1'b0;
    cyc(200);
    chk({1'b0, wr_count}, {1'b0, tmp});
    rd(OFS_STATE, 33'h10);
    inh <= 1'b1;
    cyc(4);
    exe <= 1'b0;
    cyc(10);
    run(2'h1, 32'h0001_0000, 1, 1'b1);
    $display("test blocking done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
